// *** status_event_reporting.sv ***
// status reporting hierarchy with apb register access
//
// The implementer's own choices: register access over APB and the register addresses.
module status_event_reporting (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  meas_limit,
    input  wire logic [7:0]  meas_active,
    input  wire logic [15:0] ques_src,
    input  wire logic        pretrigger_done,
    input  wire logic        trigger_seen,
    input  wire logic        acq_done,
    output logic             srq,
    output logic             irq
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // edge capture into a sticky event part; sets win over clears
    function automatic logic [15:0] event_update(
        input logic [15:0] evt,
        input logic [15:0] clr,
        input logic [15:0] cond,
        input logic [15:0] prev,
        input logic [15:0] ptr,
        input logic [15:0] ntr
    );
        logic [15:0] sets;
        sets = (ptr & cond & ~prev)
             | (ntr & ~cond & prev);
        return (evt & ~clr) | sets;
    endfunction : event_update

    function automatic logic summary(input logic [15:0] evt, input logic [15:0] en);
        return |(evt & en);
    endfunction : summary

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]  lim_ptr_reg,  lim_ptr_next;
    logic [7:0]  lim_ntr_reg,  lim_ntr_next;
    logic [7:0]  lim_en_reg,   lim_en_next;
    logic [7:0]  lim_evt_reg,  lim_evt_next;
    logic [7:0]  lim_prev_reg, lim_prev_next;
    logic [15:0] ques_ptr_reg,  ques_ptr_next;
    logic [15:0] ques_ntr_reg,  ques_ntr_next;
    logic [15:0] ques_en_reg,   ques_en_next;
    logic [15:0] ques_evt_reg,  ques_evt_next;
    logic [15:0] ques_prev_reg, ques_prev_next;
    logic [15:0] oper_ptr_reg,  oper_ptr_next;
    logic [15:0] oper_ntr_reg,  oper_ntr_next;
    logic [15:0] oper_en_reg,   oper_en_next;
    logic [15:0] oper_evt_reg,  oper_evt_next;
    logic [15:0] oper_prev_reg, oper_prev_next;
    logic [7:0]  sre_reg,      sre_next;
    logic [7:0]  esr_reg,      esr_next;
    logic [7:0]  ese_reg,      ese_next;
    logic        opc_arm_reg,  opc_arm_next;
    logic        rqs_prev_reg, rqs_prev_next;
    logic [2:0]  irq_stat_reg, irq_stat_next;
    logic [2:0]  irq_mask_reg, irq_mask_next;
    logic [31:0] prdata_reg,   prdata_next;
    logic        pslverr_reg,  pslverr_next;
    status_event_pkg::acq_state_e acq_reg, acq_next;

    // ------------------------------------------------------------
    // live conditions and summaries
    // ------------------------------------------------------------
    logic [15:0] lim_cond;
    logic [15:0] ques_cond;
    logic [15:0] oper_cond;
    logic        lim_sum;
    logic        ques_sum;
    logic        oper_sum;
    logic        esb_sum;
    logic [7:0]  stb_base;
    logic        rqs;
    logic [7:0]  stb;
    logic        acq_busy;
    logic [7:0]  addr;
    logic        mapped;
    logic        wr_done;
    logic        rd_done;

    assign lim_cond = {8'h00, meas_limit};
    assign lim_sum  = summary({8'h00, lim_evt_reg}, {8'h00, lim_en_reg});

    always_comb begin
        ques_cond = ques_src;
        ques_cond[status_event_pkg::QUES_LIMIT_BIT] = lim_sum;
    end

    always_comb begin
        oper_cond = status_event_pkg::STAT_RST;
        unique case (acq_reg)
            status_event_pkg::ACQ_IDLE: begin
            end
            status_event_pkg::ACQ_MEASURING: begin
                oper_cond[status_event_pkg::OPER_MEAS_BIT] = 1'b1;
            end
            status_event_pkg::ACQ_WAITING: begin
                oper_cond[status_event_pkg::OPER_MEAS_BIT] = 1'b1;
                oper_cond[status_event_pkg::OPER_WAIT_BIT] = 1'b1;
            end
            status_event_pkg::ACQ_TRIGGERED: begin
                oper_cond[status_event_pkg::OPER_MEAS_BIT] = 1'b1;
                oper_cond[status_event_pkg::OPER_WAIT_BIT] = 1'b1;
                oper_cond[status_event_pkg::OPER_TRIG_BIT] = 1'b1;
            end
            status_event_pkg::ACQ_FINISHED: begin
                oper_cond[status_event_pkg::OPER_WAIT_BIT] = 1'b1;
                oper_cond[status_event_pkg::OPER_TRIG_BIT] = 1'b1;
            end
            default: begin
            end
        endcase
    end

    assign ques_sum = summary(ques_evt_reg, ques_en_reg);
    assign oper_sum = summary(oper_evt_reg, oper_en_reg);
    assign esb_sum  = summary({8'h00, esr_reg}, {8'h00, ese_reg});
    assign acq_busy = oper_cond[status_event_pkg::OPER_MEAS_BIT];

    always_comb begin
        stb_base = status_event_pkg::BYTE_RST;
        stb_base[status_event_pkg::STB_QUES_BIT] = ques_sum;
        stb_base[status_event_pkg::STB_ESB_BIT]  = esb_sum;
        stb_base[status_event_pkg::STB_OPER_BIT] = oper_sum;
        rqs = |(stb_base & sre_reg);
        stb = stb_base;
        stb[status_event_pkg::STB_RQS_BIT] = rqs;
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign addr = paddr[7:0];

    always_comb begin
        unique case (addr)
            status_event_pkg::LIM_COND_OFS, status_event_pkg::LIM_PTR_OFS,
            status_event_pkg::LIM_NTR_OFS,  status_event_pkg::LIM_EN_OFS,
            status_event_pkg::LIM_EVT_OFS,  status_event_pkg::QUES_COND_OFS,
            status_event_pkg::QUES_PTR_OFS, status_event_pkg::QUES_NTR_OFS,
            status_event_pkg::QUES_EN_OFS,  status_event_pkg::QUES_EVT_OFS,
            status_event_pkg::OPER_COND_OFS, status_event_pkg::OPER_PTR_OFS,
            status_event_pkg::OPER_NTR_OFS, status_event_pkg::OPER_EN_OFS,
            status_event_pkg::OPER_EVT_OFS, status_event_pkg::STB_OFS,
            status_event_pkg::SRE_OFS,      status_event_pkg::ESR_OFS,
            status_event_pkg::ESE_OFS,      status_event_pkg::CMD_OFS,
            status_event_pkg::OPC_QUERY_OFS, status_event_pkg::IRQ_STAT_OFS,
            status_event_pkg::IRQ_MASK_OFS: mapped = (paddr[31:8] == 24'h000000);
            default: mapped = 1'b0;
        endcase
    end

    // completion query holds the access phase while an acquisition runs
    assign pready  = !(psel && (addr == status_event_pkg::OPC_QUERY_OFS) && acq_busy);
    assign wr_done = psel && penable && pready && pwrite && mapped;
    assign rd_done = psel && penable && pready && !pwrite && mapped;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg && psel && penable;
    assign srq     = rqs;
    assign irq     = |(irq_stat_reg & irq_mask_reg);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] clr;
        logic [7:0]  cmd;
        logic        opc_set;
        clr = status_event_pkg::STAT_RST;
        cmd = status_event_pkg::BYTE_RST;
        opc_set = 1'b0;
        lim_ptr_next   = lim_ptr_reg;
        lim_ntr_next   = lim_ntr_reg;
        lim_en_next    = lim_en_reg;
        ques_ptr_next  = ques_ptr_reg;
        ques_ntr_next  = ques_ntr_reg;
        ques_en_next   = ques_en_reg;
        oper_ptr_next  = oper_ptr_reg;
        oper_ntr_next  = oper_ntr_reg;
        oper_en_next   = oper_en_reg;
        sre_next       = sre_reg;
        ese_next       = ese_reg;
        irq_mask_next  = irq_mask_reg;
        lim_prev_next  = lim_cond[7:0];
        ques_prev_next = ques_cond;
        oper_prev_next = oper_cond;
        rqs_prev_next  = rqs;
        acq_next       = acq_reg;
        if (wr_done && addr == status_event_pkg::CMD_OFS) begin
            cmd = pwdata[7:0];
        end

        // register writes
        if (wr_done) begin
            unique case (addr)
                status_event_pkg::LIM_PTR_OFS:  lim_ptr_next  = pwdata[7:0];
                status_event_pkg::LIM_NTR_OFS:  lim_ntr_next  = pwdata[7:0];
                status_event_pkg::LIM_EN_OFS: begin
                    // all ones picks the measurements active now
                    lim_en_next = (pwdata[7:0] == 8'hFF) ? meas_active : pwdata[7:0];
                end
                status_event_pkg::QUES_PTR_OFS: ques_ptr_next = pwdata[15:0];
                status_event_pkg::QUES_NTR_OFS: ques_ntr_next = pwdata[15:0];
                status_event_pkg::QUES_EN_OFS:  ques_en_next  = pwdata[15:0];
                status_event_pkg::OPER_PTR_OFS: oper_ptr_next = pwdata[15:0];
                status_event_pkg::OPER_NTR_OFS: oper_ntr_next = pwdata[15:0];
                status_event_pkg::OPER_EN_OFS:  oper_en_next  = pwdata[15:0];
                status_event_pkg::SRE_OFS:      sre_next      = pwdata[7:0];
                status_event_pkg::ESE_OFS:      ese_next      = pwdata[7:0];
                status_event_pkg::IRQ_MASK_OFS: irq_mask_next = pwdata[2:0];
                default: begin
                end
            endcase
        end

        // acquisition sequence
        unique case (acq_reg)
            status_event_pkg::ACQ_IDLE, status_event_pkg::ACQ_FINISHED: begin
                if (cmd[status_event_pkg::CMD_SINGLE_BIT]) begin
                    acq_next = status_event_pkg::ACQ_MEASURING;
                end
            end
            status_event_pkg::ACQ_MEASURING: begin
                if (pretrigger_done) begin
                    acq_next = status_event_pkg::ACQ_WAITING;
                end
            end
            status_event_pkg::ACQ_WAITING: begin
                if (trigger_seen) begin
                    acq_next = status_event_pkg::ACQ_TRIGGERED;
                end
            end
            status_event_pkg::ACQ_TRIGGERED: begin
                if (acq_done) begin
                    acq_next = status_event_pkg::ACQ_FINISHED;
                end
            end
            default: acq_next = status_event_pkg::ACQ_IDLE;
        endcase

        // operation complete flag in the event status register
        opc_arm_next = opc_arm_reg;
        if (cmd[status_event_pkg::CMD_OPC_BIT]) begin
            opc_arm_next = 1'b1;
        end
        if (opc_arm_next && !acq_busy) begin
            opc_set = 1'b1;
            opc_arm_next = 1'b0;
        end

        // event parts, cleared by a read of the returned bits or by a clear command
        clr = (rd_done && addr == status_event_pkg::LIM_EVT_OFS) ? prdata_reg[15:0]
            : status_event_pkg::STAT_RST;
        if (cmd[status_event_pkg::CMD_CLS_BIT]) clr = 16'hFFFF;
        lim_evt_next = 8'(event_update({8'h00, lim_evt_reg}, clr, lim_cond,
                                       {8'h00, lim_prev_reg}, {8'h00, lim_ptr_reg},
                                       {8'h00, lim_ntr_reg}));

        clr = (rd_done && addr == status_event_pkg::QUES_EVT_OFS) ? prdata_reg[15:0]
            : status_event_pkg::STAT_RST;
        if (cmd[status_event_pkg::CMD_CLS_BIT]) clr = 16'hFFFF;
        ques_evt_next = event_update(ques_evt_reg, clr, ques_cond, ques_prev_reg,
                                     ques_ptr_reg, ques_ntr_reg);

        clr = (rd_done && addr == status_event_pkg::OPER_EVT_OFS) ? prdata_reg[15:0]
            : status_event_pkg::STAT_RST;
        if (cmd[status_event_pkg::CMD_CLS_BIT]) clr = 16'hFFFF;
        oper_evt_next = event_update(oper_evt_reg, clr, oper_cond, oper_prev_reg,
                                     oper_ptr_reg, oper_ntr_reg);

        esr_next = esr_reg;
        if (rd_done && addr == status_event_pkg::ESR_OFS) begin
            esr_next = esr_reg & ~prdata_reg[7:0];
        end
        if (cmd[status_event_pkg::CMD_CLS_BIT]) esr_next = status_event_pkg::BYTE_RST;
        if (opc_set) esr_next[status_event_pkg::ESR_OPC_BIT] = 1'b1;

        // interrupt status, write one to clear, new events win
        irq_stat_next = irq_stat_reg;
        if (wr_done && addr == status_event_pkg::IRQ_STAT_OFS) begin
            irq_stat_next = irq_stat_reg & ~pwdata[2:0];
        end
        if (rqs && !rqs_prev_reg) irq_stat_next[status_event_pkg::IRQ_SRQ_BIT] = 1'b1;
        if (opc_set) irq_stat_next[status_event_pkg::IRQ_OPC_BIT] = 1'b1;
        if (acq_reg == status_event_pkg::ACQ_TRIGGERED && acq_done) begin
            irq_stat_next[status_event_pkg::IRQ_DONE_BIT] = 1'b1;
        end

        // read data captured each cycle of a read transfer, returned from flops
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        if (psel && !pwrite) begin
            prdata_next = status_event_pkg::WORD_RST;
            unique case (addr)
                status_event_pkg::LIM_COND_OFS:  prdata_next[15:0] = lim_cond;
                status_event_pkg::LIM_PTR_OFS:   prdata_next[7:0]  = lim_ptr_reg;
                status_event_pkg::LIM_NTR_OFS:   prdata_next[7:0]  = lim_ntr_reg;
                status_event_pkg::LIM_EN_OFS:    prdata_next[7:0]  = lim_en_reg;
                status_event_pkg::LIM_EVT_OFS:   prdata_next[7:0]  = lim_evt_reg;
                status_event_pkg::QUES_COND_OFS: prdata_next[15:0] = ques_cond;
                status_event_pkg::QUES_PTR_OFS:  prdata_next[15:0] = ques_ptr_reg;
                status_event_pkg::QUES_NTR_OFS:  prdata_next[15:0] = ques_ntr_reg;
                status_event_pkg::QUES_EN_OFS:   prdata_next[15:0] = ques_en_reg;
                status_event_pkg::QUES_EVT_OFS:  prdata_next[15:0] = ques_evt_reg;
                status_event_pkg::OPER_COND_OFS: prdata_next[15:0] = oper_cond;
                status_event_pkg::OPER_PTR_OFS:  prdata_next[15:0] = oper_ptr_reg;
                status_event_pkg::OPER_NTR_OFS:  prdata_next[15:0] = oper_ntr_reg;
                status_event_pkg::OPER_EN_OFS:   prdata_next[15:0] = oper_en_reg;
                status_event_pkg::OPER_EVT_OFS:  prdata_next[15:0] = oper_evt_reg;
                status_event_pkg::STB_OFS:       prdata_next[7:0]  = stb;
                status_event_pkg::SRE_OFS:       prdata_next[7:0]  = sre_reg;
                status_event_pkg::ESR_OFS:       prdata_next[7:0]  = esr_reg;
                status_event_pkg::ESE_OFS:       prdata_next[7:0]  = ese_reg;
                status_event_pkg::OPC_QUERY_OFS: prdata_next[0]    =
                    acq_next inside {status_event_pkg::ACQ_IDLE, status_event_pkg::ACQ_FINISHED};
                status_event_pkg::IRQ_STAT_OFS:  prdata_next[2:0]  = irq_stat_reg;
                status_event_pkg::IRQ_MASK_OFS:  prdata_next[2:0]  = irq_mask_reg;
                default: begin
                end
            endcase
        end
        if (psel && !mapped) begin
            prdata_next = status_event_pkg::WORD_RST;
            pslverr_next = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            lim_ptr_reg   <= status_event_pkg::BYTE_RST;
            lim_ntr_reg   <= status_event_pkg::BYTE_RST;
            lim_en_reg    <= status_event_pkg::BYTE_RST;
            lim_evt_reg   <= status_event_pkg::BYTE_RST;
            lim_prev_reg  <= status_event_pkg::BYTE_RST;
            ques_ptr_reg  <= status_event_pkg::STAT_RST;
            ques_ntr_reg  <= status_event_pkg::STAT_RST;
            ques_en_reg   <= status_event_pkg::STAT_RST;
            ques_evt_reg  <= status_event_pkg::STAT_RST;
            ques_prev_reg <= status_event_pkg::STAT_RST;
            oper_ptr_reg  <= status_event_pkg::STAT_RST;
            oper_ntr_reg  <= status_event_pkg::STAT_RST;
            oper_en_reg   <= status_event_pkg::STAT_RST;
            oper_evt_reg  <= status_event_pkg::STAT_RST;
            oper_prev_reg <= status_event_pkg::STAT_RST;
            sre_reg       <= status_event_pkg::BYTE_RST;
            esr_reg       <= status_event_pkg::BYTE_RST;
            ese_reg       <= status_event_pkg::BYTE_RST;
            opc_arm_reg   <= 1'b0;
            rqs_prev_reg  <= 1'b0;
            irq_stat_reg  <= 3'b000;
            irq_mask_reg  <= 3'b000;
            prdata_reg    <= status_event_pkg::WORD_RST;
            pslverr_reg   <= 1'b0;
            acq_reg       <= status_event_pkg::ACQ_IDLE;
        end else begin
            lim_ptr_reg   <= lim_ptr_next;
            lim_ntr_reg   <= lim_ntr_next;
            lim_en_reg    <= lim_en_next;
            lim_evt_reg   <= lim_evt_next;
            lim_prev_reg  <= lim_prev_next;
            ques_ptr_reg  <= ques_ptr_next;
            ques_ntr_reg  <= ques_ntr_next;
            ques_en_reg   <= ques_en_next;
            ques_evt_reg  <= ques_evt_next;
            ques_prev_reg <= ques_prev_next;
            oper_ptr_reg  <= oper_ptr_next;
            oper_ntr_reg  <= oper_ntr_next;
            oper_en_reg   <= oper_en_next;
            oper_evt_reg  <= oper_evt_next;
            oper_prev_reg <= oper_prev_next;
            sre_reg       <= sre_next;
            esr_reg       <= esr_next;
            ese_reg       <= ese_next;
            opc_arm_reg   <= opc_arm_next;
            rqs_prev_reg  <= rqs_prev_next;
            irq_stat_reg  <= irq_stat_next;
            irq_mask_reg  <= irq_mask_next;
            prdata_reg    <= prdata_next;
            pslverr_reg   <= pslverr_next;
            acq_reg       <= acq_next;
        end
    end

endmodule : status_event_reporting

// *** status_event_pkg.sv ***
// constants and types of the status event reporting block
package status_event_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] LIM_COND_OFS  = 8'h00;
    localparam logic [7:0] LIM_PTR_OFS   = 8'h04;
    localparam logic [7:0] LIM_NTR_OFS   = 8'h08;
    localparam logic [7:0] LIM_EN_OFS    = 8'h0C;
    localparam logic [7:0] LIM_EVT_OFS   = 8'h10;
    localparam logic [7:0] QUES_COND_OFS = 8'h14;
    localparam logic [7:0] QUES_PTR_OFS  = 8'h18;
    localparam logic [7:0] QUES_NTR_OFS  = 8'h1C;
    localparam logic [7:0] QUES_EN_OFS   = 8'h20;
    localparam logic [7:0] QUES_EVT_OFS  = 8'h24;
    localparam logic [7:0] OPER_COND_OFS = 8'h28;
    localparam logic [7:0] OPER_PTR_OFS  = 8'h2C;
    localparam logic [7:0] OPER_NTR_OFS  = 8'h30;
    localparam logic [7:0] OPER_EN_OFS   = 8'h34;
    localparam logic [7:0] OPER_EVT_OFS  = 8'h38;
    localparam logic [7:0] STB_OFS       = 8'h3C;
    localparam logic [7:0] SRE_OFS       = 8'h40;
    localparam logic [7:0] ESR_OFS       = 8'h44;
    localparam logic [7:0] ESE_OFS       = 8'h48;
    localparam logic [7:0] CMD_OFS       = 8'h4C;
    localparam logic [7:0] OPC_QUERY_OFS = 8'h50;
    localparam logic [7:0] IRQ_STAT_OFS  = 8'h54;
    localparam logic [7:0] IRQ_MASK_OFS  = 8'h58;

    // ------------------------------------------------------------
    // field positions and widths
    // ------------------------------------------------------------
    localparam int LIM_W          = 8;
    localparam int STAT_W         = 16;
    localparam int QUES_LIMIT_BIT = 9;
    localparam int OPER_MEAS_BIT  = 4;
    localparam int OPER_WAIT_BIT  = 5;
    localparam int OPER_TRIG_BIT  = 6;
    localparam int STB_QUES_BIT   = 3;
    localparam int STB_ESB_BIT    = 5;
    localparam int STB_RQS_BIT    = 6;
    localparam int STB_OPER_BIT   = 7;
    localparam int ESR_OPC_BIT    = 0;
    localparam int CMD_CLS_BIT    = 0;
    localparam int CMD_OPC_BIT    = 1;
    localparam int CMD_SINGLE_BIT = 2;
    localparam int IRQ_SRQ_BIT    = 0;
    localparam int IRQ_OPC_BIT    = 1;
    localparam int IRQ_DONE_BIT   = 2;
    localparam int IRQ_W          = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] STAT_RST = 16'h0000;
    localparam logic [7:0]  BYTE_RST = 8'h00;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;

    typedef enum logic [2:0] {
        ACQ_IDLE      = 3'b000,
        ACQ_MEASURING = 3'b001,
        ACQ_WAITING   = 3'b010,
        ACQ_TRIGGERED = 3'b011,
        ACQ_FINISHED  = 3'b100
    } acq_state_e;

endpackage : status_event_pkg

// *** host_model.sv ***
// apb host issuing status queries
module host_model (
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata,
    input  logic        clk,
    input  logic [31:0] prdata,
    input  logic        pready,
    input  logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] q;
    logic        e;
    bit          cont = 0;
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(logic w, logic [31:0] a, d, output logic [31:0] r,
                        output logic s, input bit b);
        if (!cont) @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        s = pslverr;
        penable <= 1'b0;
        if (!b) psel <= 1'b0;
        cont = b;
    endtask : xfer
    task automatic arm_opc();
        xfer(1'b1, 32'h4C, 32'h1, q, e, 1'b0);
        xfer(1'b1, 32'h4C, 32'h2, q, e, 1'b0);
    endtask : arm_opc
endmodule : host_model

// *** status_event_reporting_assertions.sv ***
// port checker of the status reporting block
module status_event_reporting_assertions (
    input logic        clk,
    input logic        srst,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [31:0] paddr,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic [7:0]  meas_limit,
    input logic        srq,
    input logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire acc = psel && penable && !pwrite;
    property p_rst; $fell(srst) |-> !srq && !irq; endproperty
    a_rst: assert property (p_rst) else $error("srq or irq after reset");
    property p_err; acc && paddr[31:8] != 0 |-> pslverr && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("unmapped read not refused");
    property p_ok; psel && penable && paddr < 32'h5C && paddr[1:0] == 0 |-> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused");
    property p_rdy; psel && penable && paddr != 32'h50 |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("wait state on plain access");
    property p_stall; !pready |-> psel && paddr == 32'h50; endproperty
    a_stall: assert property (p_stall) else $error("stall outside completion query");
    property p_cond; acc && paddr == 32'h0 && $past(meas_limit, 2) == $past(meas_limit)
        |-> prdata == {24'h0, $past(meas_limit)}; endproperty
    a_cond: assert property (p_cond) else $error("condition read wrong");
    property p_evt2; (acc && pready && paddr == 32'h10 && meas_limit == $past(meas_limit, 3))
        ##1 (psel && !penable && paddr == 32'h10 && $stable(meas_limit)) ##1 penable
        |-> prdata == 32'h0; endproperty
    a_evt2: assert property (p_evt2) else $error("event not cleared by read");
    property p_oper; acc && paddr == 32'h28 |-> prdata inside {32'h0, 32'h10, 32'h30, 32'h70, 32'h60};
    endproperty
    a_oper: assert property (p_oper) else $error("operation weights wrong");
    c_stall: cover property (psel && !pready ##1 pready);
    c_srq: cover property (srq);
    c_irq: cover property (irq);
endmodule : status_event_reporting_assertions
bind status_event_reporting status_event_reporting_assertions chk_u (.*);

// *** testbench.sv ***
// self-checking bench of the status reporting block
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, srst = 1, pre = 0, trg = 0, done = 0, psel, penable, pwrite, pready;
    logic pslverr, srq, irq, e;
    logic [31:0] paddr, pwdata, prdata, q, lfsr = 32'hA4AA116E;
    logic [7:0] lim = 0, act = 0, ptr, ntr, cur, evt;
    logic [15:0] ques = 0;
    int err_count = 0, checked = 0, cyc = 0;
    always #2.5 clk = ~clk;
    status_event_reporting dut_u (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .meas_limit(lim), .meas_active(act), .ques_src(ques),
        .pretrigger_done(pre), .trigger_seen(trg), .acq_done(done), .srq, .irq);
    host_model host_u (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr);
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    task automatic chk(string n, logic [31:0] x, y);
        checked++;
        if (y !== x) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, x, y);
        end
    endtask : chk
    task automatic rd(logic [7:0] a, logic [31:0] x, string n, bit b = 0);
        host_u.xfer(1'b0, {24'h0, a}, 32'h0, q, e, b);
        chk(n, x, q);
    endtask : rd
    task automatic wr(logic [7:0] a, logic [31:0] d);
        host_u.xfer(1'b1, {24'h0, a}, d, q, e, 1'b0);
    endtask : wr
    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        srst <= 0;
        rd(8'h0C, 0, "lim_en");
        wr(8'h40, 8);
        wr(8'h20, 512);
        wr(8'h18, 512);
        act <= 8'h07;
        wr(8'h0C, 8'hFF);
        rd(8'h0C, 7, "lim_en_all");
        wr(8'h04, 8'hFF);
        lim <= 8'h03;
        repeat (8) @(posedge clk);
        chk("srq", 1, srq);
        rd(8'h3C, 72, "stb");
        rd(8'h24, 512, "ques_evt");
        rd(8'h10, 3, "lim_evt", 1);
        rd(8'h10, 0, "lim_evt2");
        rd(8'h00, 3, "lim_cond");
        lim <= 8'h07;
        repeat (4) @(posedge clk);
        rd(8'h10, 4, "lim_evt3");
        for (int i = 0; i < 12; i++) begin
            ptr = 8'(rnd());
            ntr = 8'(rnd());
            wr(8'h04, ptr);
            wr(8'h08, ntr);
            cur = 8'(rnd());
            evt = (cur & ~lim & ptr) | (~cur & lim & ntr);
            lim <= cur;
            repeat (4) @(posedge clk);
            rd(8'h10, evt, "lim_evt_rnd");
        end
        wr(8'h58, 2);
        wr(8'h4C, 4);
        rd(8'h28, 16, "oper");
        pre <= 1;
        rd(8'h28, 48, "oper");
        pre <= 0;
        trg <= 1;
        rd(8'h28, 112, "oper");
        trg <= 0;
        host_u.arm_opc();
        rd(8'h44, 0, "esr_busy");
        fork
            rd(8'h50, 1, "opc_query");
            begin
                repeat (6) @(posedge clk);
                done <= 1;
            end
        join
        rd(8'h28, 96, "oper_end");
        rd(8'h44, 1, "esr");
        rd(8'h44, 0, "esr2");
        wr(8'h1C, 1);
        ques <= 16'h0001;
        repeat (2) @(posedge clk);
        ques <= 16'h0000;
        repeat (4) @(posedge clk);
        rd(8'h24, 1, "ques_ntr");
        @(negedge clk);
        chk("irq", 1, irq);
        wr(8'h54, 7);
        @(negedge clk);
        chk("irq_clr", 0, irq);
        host_u.xfer(1'b0, 32'h100, 32'h0, q, e, 1'b0);
        chk("slverr", 1, e);
        end_of_test();
    end
endmodule : testbench
